// ===== dvg_pkg.sv
// constants and types for the dsp to vme bus glue
package dvg_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int IPL_DELAY_NS = 100;
    localparam int IPL_DELAY_CYC =
        (IPL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROM_ACCESS_NS = 150;
    localparam int ROM_WAIT_CYC =
        (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ROM_WAIT_LAST = 4'(ROM_WAIT_CYC - 1);

    // widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 31;
    localparam int VME_ADDR_W = 24;

    // upper strobe segments, address bits 30:28 with bit 31 taken as one
    localparam int SEG_MSB = 30;
    localparam int SEG_LSB = 28;
    localparam logic [2:0] SEG_ROM = 3'h4;
    localparam logic [2:0] SEG_VME = 3'h5;
    localparam logic [2:0] SEG_REG = 3'h7;

    // register page: bits 27:17 common to both register sets
    localparam int PAGE_MSB = 27;
    localparam int PAGE_LSB = 17;
    localparam logic [10:0] REG_PAGE = 11'h7FE;

    // cycle status codes for data read and data write
    localparam logic [3:0] CST_READ = 4'h8;
    localparam logic [3:0] CST_WRITE = 4'hC;

    typedef enum logic [2:0] {
        BC_IDLE,
        BC_MASTER,
        BC_ROM,
        BC_READY,
        BC_WAIT_END,
        BC_SEIZE,
        BC_SLAVE_EN,
        BC_GRANT
    } dvg_bc_state_t;
endpackage

// ===== dvg_bus_glue.sv
// address decoder, bus-control sequencer and reset routing
`timescale 1ns/1ps
// Functional notes
// - route reset request, delayed copy to level0
// - bridge reset output resets all this logic
// - segment at 0D000 0000h maps to A24 zero
// - lower half strobe 0, upper half strobe 1
// - decode every strobe-1 cycle on the clock
// - read or write taken from status lines
// - address bits 28-30 split eight segments
// - five selects: vme rd/wr, reg rd/wr, rom
// - register sets at 0FFFC and 0FFFD pages
// - sequencer drives enables, grant and ready
// - sequencer clock is only a cycle reference
// - master select starts cycle, master enable on
// - size acks or bus error end master cycle
// - acks or error assert the ready output
// - only external ready, high between accesses
// - local bus request begins slave cycle
// - drop dsp and master enables before slave
// - grant only after bus fully seized
// - request release ends slave, enables restored
// - one set answers bridge, one holds dsp off
// - 32-bit words, no byte swapping
module dvg_bus_glue (
    // clock and reset (reset is the bridge reset output)
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // reset routing
    input wire logic reset_req_i,
    output logic bridge_reset_input_o,
    output logic interrupt_level0_input_o,
    // dsp global bus
    input wire logic upper_half_strobe_n_i,
    input wire logic [3:0] cycle_status_i,
    input wire logic [dvg_pkg::ADDR_W-1:0] global_addr_i,
    input wire logic [dvg_pkg::DATA_W-1:0] dsp_data_i,
    output logic dsp_external_ready_n_o,
    output logic dsp_global_bus_enable_n_o,
    // decoder selects
    output logic vme_master_write_sel_n_o,
    output logic vme_master_read_sel_n_o,
    output logic bridge_reg_write_sel_n_o,
    output logic bridge_reg_read_sel_n_o,
    output logic boot_rom_read_sel_n_o,
    // bridge local bus
    input wire logic size_ack_0_n_i,
    input wire logic size_ack_1_n_i,
    input wire logic local_bus_error_n_i,
    input wire logic local_bus_request_n_i,
    input wire logic [dvg_pkg::DATA_W-1:0] bridge_data_i,
    output logic local_bus_grant_n_o,
    output logic master_seq_output_enable_n_o,
    output logic slave_seq_output_enable_n_o,
    output logic [dvg_pkg::VME_ADDR_W-1:0] vme_addr_o,
    output logic [dvg_pkg::DATA_W-1:0] data_to_bridge_o,
    output logic [dvg_pkg::DATA_W-1:0] data_to_dsp_o
);
    localparam int IPL_D = dvg_pkg::IPL_DELAY_CYC;

    // reset routing
    logic rst_fwd_q, rst_fwd_d;
    logic [IPL_D-1:0] ipl_dly_q, ipl_dly_d;

    // the level0 copy trails the forwarded request so the bridge sees
    // both inputs in the order its global reset needs
    always_comb begin
        rst_fwd_d = reset_req_i;
        ipl_dly_d = {ipl_dly_q[IPL_D-2:0], rst_fwd_q};
    end

    // these clear when the bridge answers; it has latched the request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_fwd_q <= 1'b0;
            ipl_dly_q <= '0;
        end else begin
            rst_fwd_q <= rst_fwd_d;
            ipl_dly_q <= ipl_dly_d;
        end
    end

    assign bridge_reset_input_o = rst_fwd_q;
    assign interrupt_level0_input_o = ipl_dly_q[IPL_D-1];

    // address decoder
    logic [4:0] sel_q, sel_d; // vme wr, vme rd, reg wr, reg rd, rom
    logic [dvg_pkg::VME_ADDR_W-1:0] vaddr_q, vaddr_d;
    logic [2:0] seg;
    logic is_rd, is_wr, reg_page;

    always_comb begin
        seg = global_addr_i[dvg_pkg::SEG_MSB:dvg_pkg::SEG_LSB];
        reg_page = global_addr_i[dvg_pkg::PAGE_MSB:dvg_pkg::PAGE_LSB]
            == dvg_pkg::REG_PAGE;
        is_rd = cycle_status_i == dvg_pkg::CST_READ;
        is_wr = cycle_status_i == dvg_pkg::CST_WRITE;
        sel_d = '0;
        vaddr_d = vaddr_q;
        if (!upper_half_strobe_n_i) begin
            case (seg)
                dvg_pkg::SEG_VME: begin
                    sel_d[4] = is_wr;
                    sel_d[3] = is_rd;
                    // base low bits are zero, so offset is the low field
                    vaddr_d = global_addr_i[dvg_pkg::VME_ADDR_W-1:0];
                end
                dvg_pkg::SEG_REG: begin
                    sel_d[2] = is_wr & reg_page;
                    sel_d[1] = is_rd & reg_page;
                    vaddr_d = global_addr_i[dvg_pkg::VME_ADDR_W-1:0];
                end
                dvg_pkg::SEG_ROM: sel_d[0] = is_rd;
                default: sel_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_q <= '0;
            vaddr_q <= '0;
        end else begin
            sel_q <= sel_d;
            vaddr_q <= vaddr_d;
        end
    end

    assign vme_master_write_sel_n_o = ~sel_q[4];
    assign vme_master_read_sel_n_o = ~sel_q[3];
    assign bridge_reg_write_sel_n_o = ~sel_q[2];
    assign bridge_reg_read_sel_n_o = ~sel_q[1];
    assign boot_rom_read_sel_n_o = ~sel_q[0];
    assign vme_addr_o = vaddr_q;

    // bus-control sequencer
    dvg_pkg::dvg_bc_state_t st_q, st_d;
    logic gbe_n_q, gbe_n_d, moe_n_q, moe_n_d, soe_n_q, soe_n_d;
    logic lbg_n_q, lbg_n_d, rdy_n_q, rdy_n_d;
    logic [3:0] wait_q, wait_d;
    logic master_sel, cycle_done;

    always_comb begin
        master_sel = |sel_q[4:1];
        cycle_done = (!size_ack_0_n_i && !size_ack_1_n_i)
            || !local_bus_error_n_i;
        st_d = st_q;
        wait_d = '0;
        gbe_n_d = 1'b0;
        moe_n_d = 1'b0;
        soe_n_d = 1'b1;
        lbg_n_d = 1'b1;
        rdy_n_d = 1'b1;
        case (st_q)
            dvg_pkg::BC_IDLE: begin
                // slave requests win only between dsp accesses, so a
                // master cycle in flight is never cut short
                if (!local_bus_request_n_i) begin
                    st_d = dvg_pkg::BC_SEIZE;
                end else if (master_sel) begin
                    st_d = dvg_pkg::BC_MASTER;
                end else if (sel_q[0]) begin
                    st_d = dvg_pkg::BC_ROM;
                end
            end
            dvg_pkg::BC_MASTER: begin
                if (cycle_done) begin
                    st_d = dvg_pkg::BC_READY;
                end
            end
            dvg_pkg::BC_ROM: begin
                wait_d = wait_q + 4'h1;
                if (wait_q == dvg_pkg::ROM_WAIT_LAST) begin
                    st_d = dvg_pkg::BC_READY;
                end
            end
            dvg_pkg::BC_READY: st_d = dvg_pkg::BC_WAIT_END;
            dvg_pkg::BC_WAIT_END: begin
                if (sel_q == '0) begin
                    st_d = dvg_pkg::BC_IDLE;
                end
            end
            dvg_pkg::BC_SEIZE: begin
                st_d = dvg_pkg::BC_IDLE;
                if (!local_bus_request_n_i) begin
                    st_d = dvg_pkg::BC_SLAVE_EN;
                end
            end
            dvg_pkg::BC_SLAVE_EN: begin
                st_d = dvg_pkg::BC_IDLE;
                if (!local_bus_request_n_i) begin
                    st_d = dvg_pkg::BC_GRANT;
                end
            end
            dvg_pkg::BC_GRANT: begin
                if (local_bus_request_n_i) begin
                    st_d = dvg_pkg::BC_IDLE;
                end
            end
            default: st_d = dvg_pkg::BC_IDLE;
        endcase
        // outputs follow the next state so they leave flip-flops
        case (st_d)
            dvg_pkg::BC_READY: rdy_n_d = 1'b0;
            dvg_pkg::BC_SEIZE: begin
                gbe_n_d = 1'b1;
                moe_n_d = 1'b1;
            end
            dvg_pkg::BC_SLAVE_EN: begin
                gbe_n_d = 1'b1;
                moe_n_d = 1'b1;
                soe_n_d = 1'b0;
            end
            dvg_pkg::BC_GRANT: begin
                gbe_n_d = 1'b1;
                moe_n_d = 1'b1;
                soe_n_d = 1'b0;
                lbg_n_d = 1'b0;
            end
            default: begin
                gbe_n_d = 1'b0;
                moe_n_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= dvg_pkg::BC_IDLE;
            wait_q <= '0;
            gbe_n_q <= 1'b0;
            moe_n_q <= 1'b0;
            soe_n_q <= 1'b1;
            lbg_n_q <= 1'b1;
            rdy_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            wait_q <= wait_d;
            gbe_n_q <= gbe_n_d;
            moe_n_q <= moe_n_d;
            soe_n_q <= soe_n_d;
            lbg_n_q <= lbg_n_d;
            rdy_n_q <= rdy_n_d;
        end
    end

    assign dsp_global_bus_enable_n_o = gbe_n_q;
    assign master_seq_output_enable_n_o = moe_n_q;
    assign slave_seq_output_enable_n_o = soe_n_q;
    assign local_bus_grant_n_o = lbg_n_q;
    assign dsp_external_ready_n_o = rdy_n_q;

    // data path: whole words, bit 0 stays bit 0 both ways
    logic [dvg_pkg::DATA_W-1:0] to_br_q, to_br_d, to_dsp_q, to_dsp_d;

    always_comb begin
        to_br_d = dsp_data_i;
        to_dsp_d = bridge_data_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            to_br_q <= '0;
            to_dsp_q <= '0;
        end else begin
            to_br_q <= to_br_d;
            to_dsp_q <= to_dsp_d;
        end
    end

    assign data_to_bridge_o = to_br_q;
    assign data_to_dsp_o = to_dsp_q;

    // checks
    sequence s_seized;
        gbe_n_q && moe_n_q && soe_n_q;
    endsequence
    sequence s_restored;
        !gbe_n_q && !moe_n_q && soe_n_q && lbg_n_q;
    endsequence

    a_ipl_delay: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(rst_fwd_q) |-> ##IPL_D ipl_dly_q[IPL_D-1])
        else $error("level0 copy not delayed as expected");
    a_sel_onehot: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        $onehot0(sel_q))
        else $error("more than one select active");
    a_vme_write: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (!upper_half_strobe_n_i && is_wr && seg == dvg_pkg::SEG_VME)
        |=> !vme_master_write_sel_n_o)
        else $error("vme write not selected");
    a_oe_excl: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        moe_n_q || soe_n_q)
        else $error("master and slave enables both on");
    a_seize_order: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == dvg_pkg::BC_IDLE && !local_bus_request_n_i)
        |=> s_seized ##1 (local_bus_request_n_i || !soe_n_q))
        else $error("slave enable before dsp hold off");
    a_grant_after: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        $fell(lbg_n_q) |-> gbe_n_q && moe_n_q && !$past(soe_n_q))
        else $error("grant before bus seized");
    a_slave_end: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == dvg_pkg::BC_GRANT && local_bus_request_n_i) |=> s_restored)
        else $error("enables not restored after slave cycle");
    a_ack_ready: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == dvg_pkg::BC_MASTER && cycle_done) |=> !rdy_n_q ##1 rdy_n_q)
        else $error("ready not pulsed after acknowledge");
    a_ready_idle: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_q == dvg_pkg::BC_IDLE) |-> rdy_n_q)
        else $error("ready low between accesses");
    a_data_pass: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ##1 data_to_bridge_o == $past(dsp_data_i))
        else $error("data word altered");
endmodule

// ===== dvg_bridge_model.sv
// behavioural model of the bridge chip local bus side
`timescale 1ns/1ps
module dvg_bridge_model #(
    parameter logic [31:0] DATA_VAL = 32'hC3A5_0F96
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // controls from the bench
    input wire logic master_sel_n_i,
    input wire logic [3:0] ack_delay_i,
    input wire logic use_err_i,
    input wire logic slave_go_i,
    input wire logic local_bus_grant_n_i,
    // local bus toward the glue
    output logic size_ack_0_n_o,
    output logic size_ack_1_n_o,
    output logic local_bus_error_n_o,
    output logic local_bus_request_n_o,
    output logic [31:0] bridge_data_o
);
    logic [3:0] cnt_q;
    logic ack_q;
    logic req_q;
    logic [1:0] gcnt_q;
    logic tog_q;

    // acks wait for the far bus, then stay until the select drops
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            req_q <= 1'b0;
            gcnt_q <= 2'h0;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            if (master_sel_n_i) begin
                cnt_q <= 4'h0;
                ack_q <= 1'b0;
            end else if (cnt_q == ack_delay_i) begin
                ack_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (slave_go_i) begin
                req_q <= 1'b1;
            end else if (gcnt_q == 2'h3) begin
                req_q <= 1'b0;
            end
            if (req_q && !local_bus_grant_n_i) begin
                gcnt_q <= gcnt_q + 2'h1;
            end else begin
                gcnt_q <= 2'h0;
            end
        end
    end

    assign size_ack_0_n_o = ~(ack_q & ~use_err_i);
    assign size_ack_1_n_o = ~(ack_q & ~use_err_i);
    assign local_bus_error_n_o = ~(ack_q & use_err_i);
    assign local_bus_request_n_o = ~req_q;
    // data not driven alternates each cycle between ~DATA_VAL and DATA_VAL
    assign bridge_data_o = ack_q ? DATA_VAL : ~DATA_VAL ^ {32{tog_q}};
endmodule

// ===== dvg_bus_glue_bench.sv
// self-checking bench for the dsp to vme bus glue
`timescale 1ns/1ps
`define CHK(g, e) check((g) === (e))
module dvg_bus_glue_bench;
    localparam logic [31:0] BR_DATA = 32'hC3A5_0F96;
    localparam logic [31:0] WR_DATA = 32'h8123_F00D;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reset_req_i = 1'b0;
    logic strb_n = 1'b1;
    logic [3:0] status = 4'h0;
    logic [dvg_pkg::ADDR_W-1:0] addr = 31'h0;
    logic [31:0] dsp_data = 32'h0;
    logic [3:0] ack_delay = 4'h2;
    logic use_err = 1'b0;
    logic slave_go = 1'b0;
    logic ack0_n, ack1_n, err_n, req_n, lbg_n, moe_n, soe_n;
    logic bri, lvl0, rdy_n, gbe_n, mwr_n, mrd_n, rwr_n, rrd_n, rom_n;
    logic [31:0] br_data, to_bridge, to_dsp;
    logic [23:0] vme_addr;
    logic [4:0] sels;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    assign sels = {mwr_n, mrd_n, rwr_n, rrd_n, rom_n};

    dvg_bus_glue u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_req_i(reset_req_i),
        .bridge_reset_input_o(bri), .interrupt_level0_input_o(lvl0),
        .upper_half_strobe_n_i(strb_n), .cycle_status_i(status),
        .global_addr_i(addr), .dsp_data_i(dsp_data),
        .dsp_external_ready_n_o(rdy_n), .dsp_global_bus_enable_n_o(gbe_n),
        .vme_master_write_sel_n_o(mwr_n), .vme_master_read_sel_n_o(mrd_n),
        .bridge_reg_write_sel_n_o(rwr_n), .bridge_reg_read_sel_n_o(rrd_n),
        .boot_rom_read_sel_n_o(rom_n), .size_ack_0_n_i(ack0_n),
        .size_ack_1_n_i(ack1_n), .local_bus_error_n_i(err_n),
        .local_bus_request_n_i(req_n), .bridge_data_i(br_data),
        .local_bus_grant_n_o(lbg_n), .master_seq_output_enable_n_o(moe_n),
        .slave_seq_output_enable_n_o(soe_n), .vme_addr_o(vme_addr),
        .data_to_bridge_o(to_bridge), .data_to_dsp_o(to_dsp)
    );

    dvg_bridge_model #(.DATA_VAL(BR_DATA)) u_bridge (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .master_sel_n_i(mwr_n & mrd_n & rwr_n & rrd_n),
        .ack_delay_i(ack_delay), .use_err_i(use_err), .slave_go_i(slave_go),
        .local_bus_grant_n_i(lbg_n), .size_ack_0_n_o(ack0_n),
        .size_ack_1_n_o(ack1_n), .local_bus_error_n_o(err_n),
        .local_bus_request_n_o(req_n), .bridge_data_o(br_data)
    );

    task automatic check(input bit ok);
        cmp_count++;
        if (!ok) begin
            errors++;
            $display("unexpected at %0t: value mismatch", $time);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic reset_route();
        @(negedge clk_i);
        reset_req_i = 1'b1;
        for (int i = 1; i <= 5; i++) begin
            @(negedge clk_i);
            `CHK(bri, 1'b1);
            `CHK(lvl0, (i == 5) ? 1'b1 : 1'b0);
        end
        reset_req_i = 1'b0;
        // bridge input drops at once, the level0 copy trails it
        for (int i = 1; i <= 5; i++) begin
            @(negedge clk_i);
            `CHK(bri, 1'b0);
            `CHK(lvl0, (i == 5) ? 1'b0 : 1'b1);
        end
    endtask

    task automatic decode(input logic [30:0] a, input logic [3:0] st,
                          input logic [4:0] exp);
        @(negedge clk_i);
        addr = a;
        status = st;
        strb_n = 1'b0;
        @(negedge clk_i);
        strb_n = 1'b1;
        `CHK(sels, exp);
        if (exp[4:1] != 4'hF) `CHK(vme_addr, a[23:0]);
        repeat (16) @(negedge clk_i);
        `CHK(sels, 5'h1F);
    endtask

    // one strobe-1 access held until ready; rom accesses have no acks
    task automatic master(input logic [30:0] a, input logic [3:0] st,
                          input logic err, input bit rom);
        bit got;
        bit a1;
        bit a2;
        got = 1'b0;
        a1 = 1'b0;
        a2 = 1'b0;
        use_err = err;
        @(negedge clk_i);
        addr = a;
        status = st;
        dsp_data = WR_DATA;
        strb_n = 1'b0;
        for (int i = 1; i < 40 && !got; i++) begin
            @(negedge clk_i);
            `CHK({moe_n, soe_n, gbe_n}, 3'b010);
            if (rdy_n === 1'b0) begin
                got = 1'b1;
                if (rom) begin
                    // select register and idle step come before the waits
                    `CHK(i, dvg_pkg::ROM_WAIT_CYC + 2);
                end else begin
                    `CHK({a2, a1}, 2'b01);
                end
                if (st == dvg_pkg::CST_READ && !rom) begin
                    `CHK(to_dsp, BR_DATA);
                end
                if (st == dvg_pkg::CST_WRITE) begin
                    `CHK(to_bridge, WR_DATA);
                end
            end
            a2 = a1;
            a1 = (ack0_n === 1'b0 && ack1_n === 1'b0) || err_n === 1'b0;
        end
        `CHK(got, 1'b1);
        @(negedge clk_i);
        `CHK(rdy_n, 1'b1);
        strb_n = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK({rdy_n, sels}, 6'h3F);
    endtask

    task automatic slave();
        int t_off;
        int t_soe;
        int t_g;
        int t_rel;
        t_off = -1;
        t_soe = -1;
        t_g = -1;
        t_rel = -1;
        @(negedge clk_i);
        slave_go = 1'b1;
        @(negedge clk_i);
        slave_go = 1'b0;
        for (int i = 1; i <= 25; i++) begin
            @(negedge clk_i);
            `CHK(moe_n | soe_n, 1'b1);
            if (lbg_n === 1'b0) begin
                `CHK({gbe_n, moe_n, soe_n}, 3'b110);
            end
            if (gbe_n === 1'b1 && moe_n === 1'b1 && t_off < 0) t_off = i;
            if (soe_n === 1'b0 && t_soe < 0) t_soe = i;
            if (lbg_n === 1'b0 && t_g < 0) t_g = i;
            if (t_rel >= 0 && i == t_rel + 1) begin
                `CHK({gbe_n, moe_n, soe_n, lbg_n}, 4'h3);
            end
            if (req_n === 1'b1 && t_g > 0 && t_rel < 0) t_rel = i;
        end
        `CHK(t_off, 1);
        `CHK(t_soe, 2);
        `CHK(t_g, 3);
        `CHK(t_rel > 3, 1'b1);
    endtask

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // a hang ends the run through the same report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        // the bridge's long local reset hold is cut short to save run time
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        `CHK({gbe_n, moe_n, soe_n, lbg_n, rdy_n}, 5'h07);
        `CHK({sels, bri, lvl0}, 7'h7C);
        master(31'h5000_0040, dvg_pkg::CST_WRITE, 1'b0, 1'b0);
        master(31'h5000_0080, dvg_pkg::CST_READ, 1'b0, 1'b0);
        ack_delay = 4'h6;
        master(31'h7FFC_0010, dvg_pkg::CST_WRITE, 1'b1, 1'b0);
        master(31'h7FFD_0000, dvg_pkg::CST_READ, 1'b0, 1'b0);
        master(31'h4000_0000, dvg_pkg::CST_READ, 1'b0, 1'b1);
        ack_delay = 4'h0;
        master(31'h5000_0004, dvg_pkg::CST_READ, 1'b1, 1'b0);
        slave();
        slave();
        decode(31'h5000_0010, dvg_pkg::CST_WRITE, 5'h0F);
        decode(31'h50AB_CDEF, dvg_pkg::CST_READ, 5'h17);
        decode(31'h7FFC_0000, dvg_pkg::CST_WRITE, 5'h1B);
        decode(31'h7FFD_0004, dvg_pkg::CST_READ, 5'h1D);
        decode(31'h4000_0000, dvg_pkg::CST_READ, 5'h1E);
        decode(31'h4000_0000, dvg_pkg::CST_WRITE, 5'h1F);
        decode(31'h0000_0000, dvg_pkg::CST_READ, 5'h1F);
        decode(31'h6000_0000, dvg_pkg::CST_READ, 5'h1F);
        decode(31'h7000_0000, dvg_pkg::CST_READ, 5'h1F);
        decode(31'h5000_0000, 4'h0, 5'h1F);
        reset_route();
        finish_test();
    end
endmodule
